// [core/txr_regs.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "txr_defines.svh"
module txr_regs #(
  parameter int IPG_W = 10
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire txr_pkg::txr_addr_t reg_addr_i,
  input  wire txr_pkg::txr_word_t reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output txr_pkg::txr_word_t     reg_rdata_o,
  // Transmit control
  input  wire logic              transmit_enable_i,
  input  wire logic              transmit_unit_reset_i,
  input  wire logic [IPG_W-1:0]  back_to_back_gap_count_i,
  input  wire logic [15:0]       tx_tail_offset_i,
  // Transmit engine events
  input  wire logic              desc_done_i,
  input  wire logic              tx_end_i,
  input  wire logic              tx_retry_i,
  input  wire logic              rx_seen_i,
  input  wire logic              pkt_ready_i,
  input  wire logic              gap_tick_i,
  // Engine status
  output logic                   tx_permit_o,
  output logic                   desc_pending_o,
  output logic [63:0]            desc_addr_o,
  output logic                   desc_flush_o
);
  import txr_pkg::*;

  txr_if       cfg_if ();

  logic [15:0] gap_ext_r;
  logic [27:0] base_lo_r;
  logic [31:0] base_hi_r;
  logic [12:0] len_units_r;
  txr_sel_e    sel;
  logic        gap_busy;
  logic        flush;
  logic        wr_gap;
  logic        wr_blo;
  logic        wr_bhi;
  logic        wr_len;
  logic        wr_head;

  if (IPG_W < 1 || IPG_W > 16) begin : g_chk
    $error("IPG_W out of range");
  end

  // Address decode shared by read and write paths
  function automatic txr_sel_e decode(input txr_addr_t a);
    case (a)
      `TXR_OFS_GAP_EXT:   decode = TXR_SEL_GAP;
      `TXR_OFS_BASE_LO:   decode = TXR_SEL_BLO;
      `TXR_OFS_BASE_HI:   decode = TXR_SEL_BHI;
      `TXR_OFS_BYTE_SIZE: decode = TXR_SEL_LEN;
      `TXR_OFS_HEAD:      decode = TXR_SEL_HEAD;
      default:            decode = TXR_SEL_NONE;
    endcase
  endfunction

  assign sel     = decode(reg_addr_i);
  assign wr_gap  = reg_wr_i && sel == TXR_SEL_GAP;
  assign wr_blo  = reg_wr_i && sel == TXR_SEL_BLO;
  assign wr_bhi  = reg_wr_i && sel == TXR_SEL_BHI;
  assign wr_len  = reg_wr_i && sel == TXR_SEL_LEN;
  assign wr_head = reg_wr_i && sel == TXR_SEL_HEAD;

  // Throttle register, only the low 16 bits are kept
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || transmit_unit_reset_i) begin
      gap_ext_r <= `TXR_GAP_EXT_RST;
    end else if (wr_gap) begin
      gap_ext_r <= reg_wdata_i[`TXR_GAP_EXT_MSB:0];
    end
  end

  // Ring base, low word drops the four alignment bits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || transmit_unit_reset_i) begin
      base_lo_r <= `TXR_BASE_LO_RST;
    end else if (wr_blo) begin
      base_lo_r <= reg_wdata_i[31:`TXR_BASE_LO_LSB];
    end
  end

  // Ring base, high word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || transmit_unit_reset_i) begin
      base_hi_r <= `TXR_BASE_HI_RST;
    end else if (wr_bhi) begin
      base_hi_r <= reg_wdata_i;
    end
  end

  // Ring length in 128-byte units
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || transmit_unit_reset_i) begin
      len_units_r <= `TXR_LEN_RST;
    end else if (wr_len) begin
      len_units_r <= reg_wdata_i[`TXR_LEN_MSB:`TXR_LEN_LSB];
    end
  end

  // Configuration towards the submodules
  assign cfg_if.throttle   = gap_ext_r;
  assign cfg_if.len_units  = len_units_r;
  assign cfg_if.head_wr    = wr_head;
  assign cfg_if.head_wdata = reg_wdata_i[`TXR_HEAD_MSB:0];

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (sel)
        TXR_SEL_GAP:  reg_rdata_o <= {16'h0000, gap_ext_r};
        TXR_SEL_BLO:  reg_rdata_o <= {base_lo_r, 4'h0};
        TXR_SEL_BHI:  reg_rdata_o <= base_hi_r;
        TXR_SEL_LEN:  reg_rdata_o <= {12'h000, len_units_r, 7'h00};
        TXR_SEL_HEAD: reg_rdata_o <= {16'h0000, cfg_if.head};
        default:      reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // Head offset and ring walking
  txr_head_ptr u_head (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .unit_rst_i  (transmit_unit_reset_i),
    .cfg         (cfg_if.ring),
    .enable_i    (transmit_enable_i),
    .tail_i      (tx_tail_offset_i),
    .desc_done_i (desc_done_i),
    .flush_o     (flush)
  );

  // Inter-packet gap with throttle extension
  txr_gap_timer #(
    .IPG_W (IPG_W)
  ) u_gap (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .unit_rst_i  (transmit_unit_reset_i),
    .cfg         (cfg_if.gap),
    .ipg_count_i (back_to_back_gap_count_i),
    .tx_end_i    (tx_end_i),
    .pkt_ready_i (pkt_ready_i),
    .retry_i     (tx_retry_i),
    .rx_seen_i   (rx_seen_i),
    .tick_i      (gap_tick_i),
    .busy_o      (gap_busy)
  );

  // Transmit permit, low while a gap runs or a frame has just ended
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_permit_o <= 1'b0;
    end else begin
      tx_permit_o <= !gap_busy && !tx_end_i;
    end
  end

  // Descriptors waiting between head and tail
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      desc_pending_o <= 1'b0;
    end else begin
      desc_pending_o <= transmit_enable_i && len_units_r != 13'h0000
                        && cfg_if.head != tx_tail_offset_i;
    end
  end

  // Host address of the descriptor at head
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      desc_addr_o <= 64'h0000000000000000;
    end else begin
      desc_addr_o <= {base_hi_r, base_lo_r, 4'h0}
                     + {44'h00000000000, cfg_if.head, 4'h0};
    end
  end

  // Invalidation pulse towards the engine
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      desc_flush_o <= 1'b0;
    end else begin
      desc_flush_o <= flush;
    end
  end

  // Read data and reserved bits
  a_blo_low_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_BLO |=> reg_rdata_o[3:0] == 4'h0)
    else $error("base low alignment bits not zero");
  a_len_fields: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_LEN |=> reg_rdata_o[6:0] == 7'h00
    && reg_rdata_o[31:20] == 12'h000)
    else $error("length reserved bits not zero");
  a_gap_upper_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && (sel == TXR_SEL_GAP || sel == TXR_SEL_HEAD)
    |=> reg_rdata_o[31:16] == 16'h0000)
    else $error("upper reserved bits not zero");
  a_bhi_readback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_bhi && !transmit_unit_reset_i ##1 reg_rd_i && sel == TXR_SEL_BHI
    |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("base high readback mismatch");
  a_throttle_reset: assert property (@(posedge clk_i)
    !rst_n_i |=> gap_ext_r == 16'h0000)
    else $error("throttle not cleared by reset");
  a_read_idle_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> reg_rdata_o == 32'h00000000)
    else $error("read data outside read cycle");
  a_read_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_GAP |=> reg_rdata_o == {16'h0000, $past(gap_ext_r)})
    else $error("throttle readback wrong");
  a_read_blo: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_BLO |=> reg_rdata_o == {$past(base_lo_r), 4'h0})
    else $error("base low readback wrong");
  a_read_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_LEN |=> reg_rdata_o == {12'h000, $past(len_units_r), 7'h00})
    else $error("length readback wrong");
  a_read_head: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_HEAD |=> reg_rdata_o == {16'h0000, $past(cfg_if.head)})
    else $error("head readback wrong");
  a_read_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_rd_i && sel == TXR_SEL_NONE |=> reg_rdata_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_sel_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $onehot(sel))
    else $error("register select not one-hot");

  // Register writes land, other cycles keep the value
  a_gap_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_gap && !transmit_unit_reset_i |=> gap_ext_r == $past(reg_wdata_i[`TXR_GAP_EXT_MSB:0]))
    else $error("throttle write lost");
  a_gap_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_gap && !transmit_unit_reset_i |=> $stable(gap_ext_r))
    else $error("throttle changed without write");
  a_blo_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_blo && !transmit_unit_reset_i |=> base_lo_r == $past(reg_wdata_i[31:`TXR_BASE_LO_LSB]))
    else $error("base low write lost");
  a_blo_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_blo && !transmit_unit_reset_i |=> $stable(base_lo_r))
    else $error("base low changed without write");
  a_bhi_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_bhi && !transmit_unit_reset_i |=> base_hi_r == $past(reg_wdata_i))
    else $error("base high write lost");
  a_bhi_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_bhi && !transmit_unit_reset_i |=> $stable(base_hi_r))
    else $error("base high changed without write");
  a_len_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_len && !transmit_unit_reset_i
    |=> len_units_r == $past(reg_wdata_i[`TXR_LEN_MSB:`TXR_LEN_LSB]))
    else $error("length write lost");
  a_len_keep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_len && !transmit_unit_reset_i |=> $stable(len_units_r))
    else $error("length changed without write");
  a_head_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_head && !transmit_unit_reset_i |=> cfg_if.head == $past(reg_wdata_i[`TXR_HEAD_MSB:0]))
    else $error("head write lost");
  a_unit_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    transmit_unit_reset_i |=> gap_ext_r == 16'h0000 && len_units_r == 13'h0000
    && cfg_if.head == 16'h0000)
    else $error("unit reset left state behind");

  // Engine status
  a_gap_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_end_i && back_to_back_gap_count_i != '0 && !transmit_unit_reset_i
    |=> !tx_permit_o [*2])
    else $error("permit during programmed gap");
  a_permit_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_end_i |=> !tx_permit_o)
    else $error("permit right after frame end");
  a_pending_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !transmit_enable_i |=> !desc_pending_o)
    else $error("pending while disabled");
  a_pending_tail: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_if.head == tx_tail_offset_i |=> !desc_pending_o)
    else $error("pending with head at tail");
  a_len_zero_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    len_units_r == 13'h0000 |=> !desc_pending_o)
    else $error("pending with empty ring");
  a_addr_aligned: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    desc_addr_o[3:0] == 4'h0)
    else $error("descriptor address not aligned");
  a_flush_raised: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_head && transmit_enable_i |=> ##1 desc_flush_o)
    else $error("no flush after enabled head write");
  a_flush_origin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    desc_flush_o |-> $past(wr_head && transmit_enable_i, 2))
    else $error("flush without enabled head write");
  c_throttle_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_gap && reg_wdata_i[15:0] != 16'h0000);
  c_b2b_throttled: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_end_i && pkt_ready_i && gap_ext_r != 16'h0000 ##[1:40] tx_permit_o);
endmodule
`default_nettype wire

// [core/txr_defines.svh]
`ifndef TXR_DEFINES_SVH
`define TXR_DEFINES_SVH

// Register byte offsets
`define TXR_OFS_GAP_EXT   16'h0458
`define TXR_OFS_BASE_LO   16'h3800
`define TXR_OFS_BASE_HI   16'h3804
`define TXR_OFS_BYTE_SIZE 16'h3808
`define TXR_OFS_HEAD      16'h3810

// Field positions
`define TXR_GAP_EXT_MSB   15
`define TXR_BASE_LO_LSB   4
`define TXR_LEN_MSB       19
`define TXR_LEN_LSB       7
`define TXR_HEAD_MSB      15

// Reset values
`define TXR_GAP_EXT_RST   16'h0000
`define TXR_BASE_LO_RST   28'h0000000
`define TXR_BASE_HI_RST   32'h00000000
`define TXR_LEN_RST       13'h0000
`define TXR_HEAD_RST      16'h0000

// Descriptor geometry: 16 bytes each, eight per 128-byte length unit
`define TXR_DESC_SHIFT    4
`define TXR_UNIT_SHIFT    3

// Throttle unit in ns
`define TXR_GAP_UNIT_NS   8

`endif

// [core/txr_pkg.sv]
package txr_pkg;
  typedef logic [15:0] txr_addr_t;
  typedef logic [31:0] txr_word_t;

  // One-hot register select
  typedef enum logic [5:0] {
    TXR_SEL_NONE = 6'h01,
    TXR_SEL_GAP  = 6'h02,
    TXR_SEL_BLO  = 6'h04,
    TXR_SEL_BHI  = 6'h08,
    TXR_SEL_LEN  = 6'h10,
    TXR_SEL_HEAD = 6'h20
  } txr_sel_e;

  // Gap timer states
  typedef enum logic [2:0] {
    TXR_GAP_IDLE  = 3'h1,
    TXR_GAP_BASE  = 3'h2,
    TXR_GAP_EXTRA = 3'h4
  } txr_gap_e;
endpackage

// [core/txr_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface txr_if;
  logic [15:0] throttle;
  logic [12:0] len_units;
  logic        head_wr;
  logic [15:0] head_wdata;
  logic [15:0] head;

  modport regs (output throttle, output len_units, output head_wr, output head_wdata,
                input head);
  modport ring (input len_units, input head_wr, input head_wdata, output head);
  modport gap  (input throttle);
endinterface
`default_nettype wire

// [core/txr_gap_timer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "txr_defines.svh"
module txr_gap_timer #(
  parameter int IPG_W = 10
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             unit_rst_i,
  // Configuration
  txr_if.gap                    cfg,
  input  wire logic [IPG_W-1:0] ipg_count_i,
  // Transmit events
  input  wire logic             tx_end_i,
  input  wire logic             pkt_ready_i,
  input  wire logic             retry_i,
  input  wire logic             rx_seen_i,
  input  wire logic             tick_i,
  output logic                  busy_o
);
  import txr_pkg::*;

  txr_gap_e         state_r;
  logic [IPG_W-1:0] base_r;
  logic [15:0]      extra_r;

  if (IPG_W < 1 || IPG_W > 16) begin : g_chk
    $error("IPG_W out of range");
  end

  // Gap sequence: programmed gap count first, then throttle units
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || unit_rst_i) begin
      state_r <= TXR_GAP_IDLE;
      base_r  <= '0;
      extra_r <= '0;
    end else if (tx_end_i) begin
      state_r <= TXR_GAP_BASE;
      base_r  <= ipg_count_i;
      // Extra delay only for a waiting back-to-back packet, never a retry
      extra_r <= (pkt_ready_i && !retry_i) ? cfg.throttle : 16'h0000;
    end else begin
      case (state_r)
        TXR_GAP_IDLE: begin
          state_r <= TXR_GAP_IDLE;
        end
        TXR_GAP_BASE: begin
          if (base_r == '0) begin
            state_r <= TXR_GAP_EXTRA;
          end else if (tick_i) begin
            base_r <= base_r - 1'b1;
          end
          if (rx_seen_i) begin
            extra_r <= 16'h0000;
          end
        end
        TXR_GAP_EXTRA: begin
          if (extra_r == 16'h0000 || rx_seen_i) begin
            state_r <= TXR_GAP_IDLE;
            extra_r <= 16'h0000;
          end else if (tick_i) begin
            extra_r <= extra_r - 1'b1;
          end
        end
        default: begin
          state_r <= TXR_GAP_IDLE;
        end
      endcase
    end
  end

  assign busy_o = (state_r != TXR_GAP_IDLE);

  a_retry_no_extra: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_end_i && retry_i && !unit_rst_i |=> extra_r == 16'h0000)
    else $error("throttle applied to retransmission");
  a_extra_loaded: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_end_i && pkt_ready_i && !retry_i && !unit_rst_i |=> extra_r == $past(cfg.throttle))
    else $error("throttle not loaded for back-to-back packet");
  a_rx_drops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_seen_i && !tx_end_i && state_r != TXR_GAP_IDLE |=> extra_r == 16'h0000)
    else $error("throttle kept after receive");
  c_gap_extra: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    state_r == TXR_GAP_EXTRA && tick_i);
endmodule
`default_nettype wire

// [core/txr_head_ptr.sv]
`timescale 1ns/1ns
`default_nettype none
`include "txr_defines.svh"
module txr_head_ptr (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        unit_rst_i,
  // Ring configuration and head
  txr_if.ring              cfg,
  // Engine side
  input  wire logic        enable_i,
  input  wire logic [15:0] tail_i,
  input  wire logic        desc_done_i,
  output logic             flush_o
);
  import txr_pkg::*;

  logic [15:0] head_r;
  logic [15:0] head_nxt;
  logic [15:0] desc_cnt;

  // Length counts 128-byte units, so descriptors come in eights
  assign desc_cnt = {cfg.len_units, 3'h0};

  // Advance and wrap at ring end
  always_comb begin
    head_nxt = head_r + 16'h0001;
    if ({1'b0, head_nxt} >= {1'b0, desc_cnt}) begin
      head_nxt = 16'h0000;
    end
  end

  // Head offset owned by hardware; software load is accepted
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || unit_rst_i) begin
      head_r <= `TXR_HEAD_RST;
    end else if (cfg.head_wr) begin
      head_r <= cfg.head_wdata;
    end else if (enable_i && desc_done_i && head_r != tail_i && desc_cnt != 16'h0000) begin
      head_r <= head_nxt;
    end
  end

  // Loading head while enabled invalidates cached descriptors
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= cfg.head_wr && enable_i;
    end
  end

  assign cfg.head = head_r;

  a_head_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    enable_i && desc_done_i && !cfg.head_wr && !unit_rst_i && desc_cnt != 16'h0000
    && head_r != tail_i && head_r == desc_cnt - 16'h0001 |=> head_r == 16'h0000)
    else $error("head did not wrap");
  a_head_stops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    head_r == tail_i && !cfg.head_wr && !unit_rst_i |=> head_r == $past(head_r))
    else $error("head moved past tail");
  a_flush_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg.head_wr && enable_i |=> flush_o ##1 !flush_o || $past(cfg.head_wr))
    else $error("flush not raised on enabled head write");
  c_head_wrap: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    head_r != 16'h0000 ##1 head_r == 16'h0000);
endmodule
`default_nettype wire

// [tb/txr_eng_model.sv]
`timescale 1ns/1ns
`default_nettype none
module txr_eng_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Pacing controls
  input  wire logic slow_i,
  input  wire logic run_i,
  input  wire logic pending_i,
  // Engine events
  output logic      done_o,
  output logic      tick_o
);
  logic [1:0] div_r;

  // Free divider for the slow pace
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // MAC tick and descriptor completion, every cycle or every fourth
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      tick_o <= !slow_i || (div_r == 2'h0);
      done_o <= run_i && pending_i && (!slow_i || (div_r == 2'h0)); // From run and pending, paced like the tick by slow_i
    end
  end
endmodule
`default_nettype wire

// [tb/tx_ring_regs_gap_throttle_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "txr_defines.svh"
module tx_ring_regs_gap_throttle_tb_top;
  import txr_pkg::*;
  logic        clk, rst_n, reg_wr, reg_rd, en, urst, tx_end, retry, rx_seen;
  logic        pkt_ready, slow, run, done, tick, permit, pending, flush;
  txr_addr_t   addr;
  txr_word_t   wdata, rdata, rv, lo, hi;
  logic [9:0]  gapc;
  logic [15:0] tail;
  logic [63:0] daddr;
  int          n_fail, compares, n_flush, n0, g, t, n;
  txr_addr_t   ofs [6] = '{`TXR_OFS_GAP_EXT, `TXR_OFS_BASE_LO, `TXR_OFS_BASE_HI,
                           `TXR_OFS_BYTE_SIZE, `TXR_OFS_HEAD, 16'h0400};

  txr_regs #(.IPG_W(10)) uut (
    .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .transmit_enable_i(en),
    .transmit_unit_reset_i(urst), .back_to_back_gap_count_i(gapc),
    .tx_tail_offset_i(tail), .desc_done_i(done), .tx_end_i(tx_end), .tx_retry_i(retry),
    .rx_seen_i(rx_seen), .pkt_ready_i(pkt_ready), .gap_tick_i(tick),
    .tx_permit_o(permit), .desc_pending_o(pending), .desc_addr_o(daddr),
    .desc_flush_o(flush));

  txr_eng_model eng (
    .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .run_i(run), .pending_i(pending),
    .done_o(done), .tick_o(tick));

  // Clock, one-cycle pulse release and flush counting
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (tx_end) tx_end <= 1'b0;
    if (rx_seen) rx_seen <= 1'b0;
    if (urst) urst <= 1'b0;
    if (flush === 1'b1) n_flush++;
  end

  // Shared mismatch report
  task automatic note(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input txr_word_t got, input txr_word_t exp);
    note({32'h0, got}, {32'h0, exp});
  endtask
  task automatic chk_addr(input logic [63:0] got, input logic [63:0] exp);
    note(got, exp);
  endtask
  task automatic chk_cnt(input int got, input int exp);
    note(64'(got), 64'(exp));
  endtask

  // Register bus cycles
  task automatic wr(input txr_addr_t a, input txr_word_t d);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input txr_addr_t a, output txr_word_t d);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic wrrd(input txr_addr_t a, input txr_word_t d, output txr_word_t q);
    addr <= a;
    wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask

  // Bounded waits on design status
  task automatic wait_sig(input logic which, input logic v);
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      if ((which ? pending : permit) === v) return;
    end
    n_fail++;
  endtask

  // Readback value from address and written word
  function automatic txr_word_t exp_rd(input txr_addr_t a, input txr_word_t d);
    case (a)
      `TXR_OFS_GAP_EXT:   return d & 32'h0000FFFF;
      `TXR_OFS_BASE_LO:   return d & 32'hFFFFFFF0;
      `TXR_OFS_BASE_HI:   return d;
      `TXR_OFS_BYTE_SIZE: return d & 32'h000FFF80;
      `TXR_OFS_HEAD:      return d & 32'h0000FFFF;
      default:            return 32'h0;
    endcase
  endfunction

  // Cycles the permit stays low after a transmission end
  function automatic int exp_gap(input int g, input int t, input logic b, r, x);
    return 3 + g + ((b && !r && !x) ? t : 0);
  endfunction

  // One gap: program throttle, end a frame, count blocked cycles
  task automatic gap_run(input int g, input int t, input logic b, r, x, output int cnt);
    wr(`TXR_OFS_GAP_EXT, 32'(t));
    gapc <= g[9:0];
    pkt_ready <= b;
    retry <= r;
    wait_sig(1'b0, 1'b1);
    tx_end <= 1'b1;
    @(posedge clk);
    rx_seen <= x;
    cnt = 0;
    for (int k = 0; k < 300; k++) begin
      @(negedge clk);
      if (permit === 1'b1) break;
      cnt++;
    end
  endtask

  task automatic wrap_up;
    $display("counts compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog on total run time
  initial begin
    #(50 * 40000);
    n_fail++;
    wrap_up;
  end

  // Main sequence
  initial begin
    {clk, rst_n, reg_wr, reg_rd, en, urst, tx_end, retry, rx_seen, pkt_ready, slow} = '0;
    {addr, wdata, gapc, tail} = '0;
    run = 1'b1;
    n_fail = 0;
    compares = 0;
    n_flush = 0;
    rv = $urandom(81185);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) begin
      rd(ofs[i], rv);
      chk_word(rv, 32'h0);
    end
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      foreach (ofs[i]) begin
        lo = (k == 0) ? 32'hFFFFFFFF : $urandom();
        wrrd(ofs[i], lo, rv);
        chk_word(rv, exp_rd(ofs[i], lo));
      end
    end
    $display("test register fields done");
    lo = $urandom();
    hi = $urandom();
    wr(`TXR_OFS_BASE_LO, lo);
    wr(`TXR_OFS_BASE_HI, hi);
    wr(`TXR_OFS_BYTE_SIZE, 32'h00000080);
    wr(`TXR_OFS_HEAD, 32'h0);
    n0 = n_flush;
    tail <= 16'h0003;
    en <= 1'b1;
    wait_sig(1'b1, 1'b1);
    wait_sig(1'b1, 1'b0);
    rd(`TXR_OFS_HEAD, rv);
    chk_word(rv, 32'h3);
    chk_addr(daddr, {hi, lo & 32'hFFFFFFF0} + 64'h30);
    slow <= 1'b1;
    tail <= 16'h0001;
    wait_sig(1'b1, 1'b1);
    wait_sig(1'b1, 1'b0);
    rd(`TXR_OFS_HEAD, rv);
    chk_word(rv, 32'h1);
    chk_addr(daddr, {hi, lo & 32'hFFFFFFF0} + 64'h10);
    chk_cnt(n_flush - n0, 0);
    run <= 1'b0;
    wr(`TXR_OFS_HEAD, 32'h2);
    repeat (3) @(posedge clk);
    chk_cnt(n_flush - n0, 1);
    en <= 1'b0;
    run <= 1'b1;
    slow <= 1'b0;
    $display("test ring walk done");
    for (int k = 0; k < 14; k++) begin
      g = 1 + $urandom_range(11);
      t = (k == 0) ? 0 : $urandom_range(40);
      gap_run(g, t, k[0] | (k < 3), k % 5 == 4, (k % 4 == 3) && g >= 2, n);
      chk_cnt(n, exp_gap(g, t, k[0] | (k < 3), k % 5 == 4, (k % 4 == 3) && g >= 2));
    end
    $display("test gap throttle done");
    wr(`TXR_OFS_GAP_EXT, 32'h9);
    urst <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`TXR_OFS_GAP_EXT, rv);
    chk_word(rv, 32'h0);
    rd(`TXR_OFS_HEAD, rv);
    chk_word(rv, 32'h0);
    $display("test unit reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
